// ### logic/scmrc_regs.svh
// Offsets, field positions, reset values and counts of the slow clock
// meter and reset cause block. Definitions only.
`ifndef SCMRC_REGS_SVH
`define SCMRC_REGS_SVH

`define SCMRC_OFF_CAUSE 8'h08
`define SCMRC_OFF_WINDOW 8'h0c
`define SCMRC_OFF_PERIOD 8'h10
`define SCMRC_OFF_FREQ 8'h14
`define SCMRC_OFF_IRQ 8'h18
`define SCMRC_OFF_MASK 8'h1c

`define SCMRC_CAUSE_RST 32'h0000_0005
`define SCMRC_CAUSE_RSVD0 0
`define SCMRC_CAUSE_BOR 1
`define SCMRC_CAUSE_POR 2
`define SCMRC_CAUSE_PIN_LO 3
`define SCMRC_CAUSE_RADIO1 8
`define SCMRC_CAUSE_RADIO2 10

`define SCMRC_WINDOW_RST 9'h00f
`define SCMRC_WINDOW_AUTO 9'h010
`define SCMRC_PERIOD_W 19
`define SCMRC_FREQ_W 27
`define SCMRC_IRQ_BIT 0
`define SCMRC_MASK_RST 1'h1

// Clock rates in MHz; clk ticks are scaled to reference half-periods
`define SCMRC_CLK_MHZ 10
`define SCMRC_REF_MHZ 16
`define SCMRC_STEP (2 * `SCMRC_REF_MHZ)
`define SCMRC_FREQ_NUM 40'h80_0000_0000

`endif

// ### logic/scmrc_pkg.sv
// Types shared by the slow clock meter and reset cause block.
// Assumes scmrc_regs.svh supplies the numeric constants.
package scmrc_pkg;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } scmrc_bus_t;

   typedef struct packed {
      logic brownoutCauseFlag;
      logic porFlag;
      logic [4:0] pinWakeFlag;
      logic radioTimer1WakeFlag;
      logic radioTimer2WakeFlag;
   } scmrc_cause_t;

   typedef enum logic [1:0] {
      SCMRC_IDLE = 2'b00,
      SCMRC_COUNT = 2'b01,
      SCMRC_DIV_PERIOD = 2'b10,
      SCMRC_DIV_FREQ = 2'b11
   } scmrc_state_t;

endpackage

// ### logic/scmrc_period_counter.sv
// Counts clk cycles across a window of slow clock rising edges.
// Assumes slowClk is asynchronous to clk and much slower than it.
`timescale 1ns/10ps
`include "scmrc_regs.svh"

module scmrc_period_counter (
   input logic clk,
   input logic rst_n,
   input logic slowClk,
   input logic start,
   input logic [8:0] window,
   output logic done,
   output logic [23:0] ticks
);
   logic [2:0] slowSync_q;
   logic armed_q;
   logic run_q;
   logic done_q;
   logic [8:0] remain_q;
   logic [23:0] ticks_q;
   wire slowRise = slowSync_q[1] & ~slowSync_q[2];

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         slowSync_q <= 3'h0;
      end else begin
         slowSync_q <= {slowSync_q[1:0], slowClk};
      end
   end

   // Window starts on the first rising edge after start
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         armed_q <= 1'b0;
         run_q <= 1'b0;
         done_q <= 1'b0;
         remain_q <= 9'h000;
         ticks_q <= 24'h000000;
      end else if (start) begin
         armed_q <= 1'b1;
         run_q <= 1'b0;
         done_q <= 1'b0;
         // Zero length would wrap and run 512 periods; taken as one period
         remain_q <= (window == 9'h000) ? 9'h001 : window;
         ticks_q <= 24'h000000;
      end else begin
         done_q <= 1'b0;
         if (armed_q && slowRise) begin
            armed_q <= 1'b0;
            run_q <= 1'b1;
         end else if (run_q) begin
            ticks_q <= ticks_q + 24'h000001;
            if (slowRise) begin
               remain_q <= remain_q - 9'h001;
               if (remain_q == 9'h001) begin
                  run_q <= 1'b0;
                  done_q <= 1'b1;
               end
            end
         end
      end
   end

   assign done = done_q;
   assign ticks = ticks_q;
endmodule // scmrc_period_counter

// ### logic/scmrc_divider.sv
// Restoring divider, one quotient bit per clk, 40 cycles per division.
// Assumes start is a one-cycle pulse; a new start restarts it.
`timescale 1ns/10ps

module scmrc_divider (
   input logic clk,
   input logic rst_n,
   input logic start,
   input logic [39:0] num,
   input logic [23:0] den,
   output logic done,
   output logic [39:0] quo
);
   logic busy_q;
   logic done_q;
   logic [5:0] cnt_q;
   logic [39:0] quo_q;
   logic [24:0] rem_q;
   logic [23:0] den_q;
   wire [24:0] trial = {rem_q[23:0], quo_q[39]};
   wire fits = trial >= {1'b0, den_q};

   // Zero divisor gives all ones; callers treat that as saturation
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy_q <= 1'b0;
         done_q <= 1'b0;
         cnt_q <= 6'h00;
         quo_q <= 40'h0;
         rem_q <= 25'h0;
         den_q <= 24'h0;
      end else if (start) begin
         busy_q <= 1'b1;
         done_q <= 1'b0;
         cnt_q <= 6'h28;
         quo_q <= num;
         rem_q <= 25'h0;
         den_q <= den;
      end else begin
         done_q <= 1'b0;
         if (busy_q) begin
            rem_q <= fits ? trial - {1'b0, den_q} : trial;
            quo_q <= {quo_q[38:0], fits};
            cnt_q <= cnt_q - 6'h01;
            if (cnt_q == 6'h01) begin
               busy_q <= 1'b0;
               done_q <= 1'b1;
            end
         end
      end
   end

   assign done = done_q;
   assign quo = quo_q;
endmodule // scmrc_divider

// ### logic/scmrc_top.sv
// Slow clock meter and reset/wake cause registers.
// Assumes slowClk, cause events and power mode come from other domains.
// How it works
// - Cause register: brown-out, power-on, five pin wakes; read only
// - Bit 8 marks radio timer 1 wake, bit 10 radio timer 2 wake
// - Nine-bit window length, read-write, resets to fifteen
// - Period result is window length in reference half-periods
// - Entry into second active power mode measures with window sixteen
// - Zero written to period result starts a programmed-window run
// - Frequency result is two to the 39 over the period
// - Measurement end sets pending bit zero of interrupt register
// - Writing one to bit zero clears pending; zero leaves it
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/10ps
`include "scmrc_regs.svh"

module scmrc_top (
   input logic clk,
   input logic rst_n,
   input scmrc_pkg::scmrc_bus_t busReq,
   output logic [31:0] rdData,
   input logic slowClk,
   input scmrc_pkg::scmrc_cause_t causeEvt,
   input logic secondActivePowerMode,
   output logic irq
);
   import scmrc_pkg::*;

   scmrc_state_t state_q;
   scmrc_state_t state_d;
   logic [31:0] cause_q;
   logic [8:0] window_q;
   logic [18:0] period_q;
   logic [26:0] freq_q;
   logic [18:0] periodTmp_q;
   logic measureDonePending_q;
   logic mask_q;
   logic [31:0] rdData_q;
   logic [2:0] modeSync_q;
   logic [8:0] causeSync0_q;
   logic [8:0] causeSync1_q;
   logic [8:0] causeSync2_q;
   logic cntDone;
   logic divDone;
   logic [23:0] ticks;
   logic [39:0] quo;
   logic [8:0] causeRaw;
   logic [8:0] causeRise;

   // Bus decode
   wire hitCause = busReq.addr == `SCMRC_OFF_CAUSE;
   wire hitWindow = busReq.addr == `SCMRC_OFF_WINDOW;
   wire hitPeriod = busReq.addr == `SCMRC_OFF_PERIOD;
   wire hitFreq = busReq.addr == `SCMRC_OFF_FREQ;
   wire hitIrq = busReq.addr == `SCMRC_OFF_IRQ;
   wire hitMask = busReq.addr == `SCMRC_OFF_MASK;
   wire wrWindow = busReq.wr & hitWindow;
   wire wrIrq = busReq.wr & hitIrq;
   wire wrMask = busReq.wr & hitMask;

   // Launches
   wire swLaunch = busReq.wr & hitPeriod & (busReq.wdata == 32'h0);
   wire modeRise = modeSync_q[1] & ~modeSync_q[2];
   wire autoLaunch = modeRise;
   wire launch = swLaunch | autoLaunch;
   // Auto launch wins a tie: its fixed window must not be overridden
   wire [8:0] cntWindow = autoLaunch ? `SCMRC_WINDOW_AUTO
      : window_q;

   // Divider feed: ticks scaled to half-periods, then reciprocal
   wire inCount = state_q == SCMRC_COUNT;
   wire inDivP = state_q == SCMRC_DIV_PERIOD;
   wire inDivF = state_q == SCMRC_DIV_FREQ;
   wire [39:0] ticksScaled = 40'(ticks) * 40'(`SCMRC_STEP);
   wire divStart = (inCount & cntDone & ~launch)
      | (inDivP & divDone & ~launch);
   wire [39:0] divNum = inCount ? ticksScaled : `SCMRC_FREQ_NUM;
   wire [23:0] divDen = inCount ? 24'(`SCMRC_CLK_MHZ)
      : {5'h00, quo[18:0]};
   wire finish = inDivF & divDone & ~launch;

   // Read mux
   wire [31:0] rdWindow = {23'h0, window_q};
   wire [31:0] rdPeriod = {13'h0, period_q};
   wire [31:0] rdFreq = {5'h0, freq_q};
   wire [31:0] rdIrq = {31'h0, measureDonePending_q};
   wire [31:0] rdMask = {31'h0, mask_q};
   wire [31:0] rdMux = hitCause ? cause_q
      : hitWindow ? rdWindow
      : hitPeriod ? rdPeriod
      : hitFreq ? rdFreq
      : hitIrq ? rdIrq
      : hitMask ? rdMask
      : 32'h0;

   assign causeRaw = causeEvt;
   assign causeRise = causeSync1_q & ~causeSync2_q;

   // Per-source synchronisers for the cause events
   genvar gi;
   generate
      for (gi = 0; gi < 9; gi = gi + 1) begin : g_causeSync
         always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
               causeSync0_q[gi] <= 1'b0;
               causeSync1_q[gi] <= 1'b0;
               causeSync2_q[gi] <= 1'b0;
            end else begin
               causeSync0_q[gi] <= causeRaw[gi];
               causeSync1_q[gi] <= causeSync0_q[gi];
               causeSync2_q[gi] <= causeSync1_q[gi];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         modeSync_q <= 3'h0;
      end else begin
         modeSync_q <= {modeSync_q[1:0], secondActivePowerMode};
      end
   end

   // Newest cause replaces the old one; bus writes have no effect
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cause_q <= `SCMRC_CAUSE_RST;
      end else if (|causeRise) begin
         cause_q <= {21'h0, causeRise[0], 1'b0, causeRise[1],
                     causeRise[6:2], causeRise[7], causeRise[8],
                     1'b1};
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         window_q <= `SCMRC_WINDOW_RST;
      end else if (wrWindow) begin
         window_q <= busReq.wdata[8:0];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mask_q <= `SCMRC_MASK_RST;
      end else if (wrMask) begin
         mask_q <= busReq.wdata[0];
      end
   end

   // Set beats a clear landing in the same cycle
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         measureDonePending_q <= 1'b0;
      end else if (finish) begin
         measureDonePending_q <= 1'b1;
      end else if (wrIrq && busReq.wdata[`SCMRC_IRQ_BIT]) begin
         measureDonePending_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         period_q <= 19'h0;
         freq_q <= 27'h0;
         periodTmp_q <= 19'h0;
      end else begin
         if (inDivP && divDone) begin
            periodTmp_q <= quo[18:0];
         end
         if (finish) begin
            period_q <= periodTmp_q;
            freq_q <= quo[26:0];
         end
      end
   end

   always_comb begin
      state_d = state_q;
      case (state_q)
         SCMRC_IDLE: begin
            if (launch) begin
               state_d = SCMRC_COUNT;
            end
         end
         SCMRC_COUNT: begin
            if (launch) begin
               state_d = SCMRC_COUNT;
            end else if (cntDone) begin
               state_d = SCMRC_DIV_PERIOD;
            end
         end
         SCMRC_DIV_PERIOD: begin
            if (launch) begin
               state_d = SCMRC_COUNT;
            end else if (divDone) begin
               state_d = SCMRC_DIV_FREQ;
            end
         end
         SCMRC_DIV_FREQ: begin
            if (launch) begin
               state_d = SCMRC_COUNT;
            end else if (divDone) begin
               state_d = SCMRC_IDLE;
            end
         end
         default: begin
            state_d = SCMRC_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= SCMRC_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // Read data valid only in the cycle after the strobe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rdData_q <= 32'h0;
      end else begin
         rdData_q <= busReq.rd ? rdMux : 32'h0;
      end
   end

   assign rdData = rdData_q;
   assign irq = measureDonePending_q & mask_q;

   scmrc_period_counter u_counter (
      .clk(clk),
      .rst_n(rst_n),
      .slowClk(slowClk),
      .start(launch),
      .window(cntWindow),
      .done(cntDone),
      .ticks(ticks)
   );

   scmrc_divider u_divider (
      .clk(clk),
      .rst_n(rst_n),
      .start(divStart),
      .num(divNum),
      .den(divDen),
      .done(divDone),
      .quo(quo)
   );

   property p_cause_ro;
      @(posedge clk) disable iff (!rst_n)
      (busReq.wr && hitCause && !(|causeRise)) |=> $stable(cause_q);
   endproperty
   a_cause_ro: assert property (p_cause_ro)
      else $error("Cause register changed on a bus write");

   property p_radio_cause;
      @(posedge clk) disable iff (!rst_n)
      (causeRise[1] || causeRise[0])
         |=> (cause_q[`SCMRC_CAUSE_RADIO1] == $past(causeRise[1]))
         && (cause_q[`SCMRC_CAUSE_RADIO2] == $past(causeRise[0]));
   endproperty
   a_radio_cause: assert property (p_radio_cause)
      else $error("Radio timer wake bits do not follow their events");

   property p_window_wr;
      @(posedge clk) disable iff (!rst_n)
      wrWindow |=> window_q == $past(busReq.wdata[8:0]);
   endproperty
   a_window_wr: assert property (p_window_wr)
      else $error("Window length not stored");

   property p_period_rd;
      @(posedge clk) disable iff (!rst_n)
      (busReq.rd && hitPeriod) |=> rdData == {13'h0, $past(period_q)};
   endproperty
   a_period_rd: assert property (p_period_rd)
      else $error("Period read data wrong");

   property p_auto_window;
      @(posedge clk) disable iff (!rst_n)
      autoLaunch |=> u_counter.remain_q == 9'h010;
   endproperty
   a_auto_window: assert property (p_auto_window)
      else $error("Automatic measurement not using window of sixteen");

   property p_sw_launch;
      @(posedge clk) disable iff (!rst_n)
      (swLaunch && !autoLaunch)
         |-> cntWindow == window_q ##1 state_q == SCMRC_COUNT;
   endproperty
   a_sw_launch: assert property (p_sw_launch)
      else $error("Zero write to period did not launch measurement");

   property p_freq_rd;
      @(posedge clk) disable iff (!rst_n)
      (busReq.rd && hitFreq) |=> rdData[31:27] == 5'h0
         && rdData[26:0] == $past(freq_q);
   endproperty
   a_freq_rd: assert property (p_freq_rd)
      else $error("Frequency read data wrong");

   property p_done_irq;
      @(posedge clk) disable iff (!rst_n)
      finish |=> measureDonePending_q && (irq == mask_q);
   endproperty
   a_done_irq: assert property (p_done_irq)
      else $error("Completion did not raise pending interrupt");

   property p_w1c;
      @(posedge clk) disable iff (!rst_n)
      (wrIrq && !finish)
         |=> measureDonePending_q
            == ($past(measureDonePending_q) && !$past(busReq.wdata[0]));
   endproperty
   a_w1c: assert property (p_w1c)
      else $error("Interrupt clear by write one misbehaved");

   property p_results_stable;
      @(posedge clk) disable iff (!rst_n)
      !finish |=> $stable(period_q) && $stable(freq_q);
   endproperty
   a_results_stable: assert property (p_results_stable)
      else $error("Results changed outside completion");

   property p_results_together;
      @(posedge clk) disable iff (!rst_n)
      $changed(period_q) |-> $rose(measureDonePending_q)
         || ($past(finish) && measureDonePending_q);
   endproperty
   a_results_together: assert property (p_results_together)
      else $error("Period updated without completion interrupt");

endmodule // scmrc_top

// ### test/scmrc_testbench.sv
// Self-checking bench for the slow clock meter and reset cause block.
// Assumes scmrc_pkg is compiled first and scmrc_regs.svh is on the path.
`timescale 1ns/10ps
`include "scmrc_regs.svh"

`define CHK(nm, ex, got) begin \
   num_checks++; \
   if ((got) !== (ex)) begin \
      failures++; \
      $display("BAD %s exp %h got %h", nm, ex, got); \
   end \
end

module testbench;
   import scmrc_pkg::*;
   // Slow clock period in clk cycles, about 32.8 kHz
   localparam int SLOW_P = 305;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   scmrc_bus_t busReq = '0;
   logic [31:0] rdData;
   logic slowClk = 1'b0;
   scmrc_cause_t causeEvt = '0;
   logic secondActivePowerMode = 1'b0;
   logic irq;
   int failures = 0;
   int num_checks = 0;
   int cycles = 0;
   int slowCnt = 0;
   int bitMap [9] = '{10, 8, 3, 4, 5, 6, 7, 2, 1};
   logic [31:0] rv;
   logic [31:0] expWin;
   logic [31:0] expCause;
   logic [8:0] win;

   scmrc_top dut_u (
      .clk(clk),
      .rst_n(rst_n),
      .busReq(busReq),
      .rdData(rdData),
      .slowClk(slowClk),
      .causeEvt(causeEvt),
      .secondActivePowerMode(secondActivePowerMode),
      .irq(irq)
   );

   always #50 clk = ~clk;

   // Free-running slow clock with an exact period in clk cycles
   always @(posedge clk) begin
      slowCnt <= (slowCnt == SLOW_P - 1) ? 0 : slowCnt + 1;
      slowClk <= (slowCnt < SLOW_P / 2);
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         failures++;
         results();
      end
   end

   task automatic results();
      if (failures == 0 && num_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task automatic wrReg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      busReq.addr <= a;
      busReq.wdata <= d;
      busReq.wr <= 1'b1;
      @(posedge clk);
      busReq.wr <= 1'b0;
   endtask

   task automatic rdReg(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      busReq.addr <= a;
      busReq.rd <= 1'b1;
      @(posedge clk);
      busReq.rd <= 1'b0;
      // Data stand only up to this edge; taken before it updates
      @(posedge clk);
      d = rdData;
   endtask

   // Poll the interrupt line with a bounded wait
   task automatic waitIrq(input int maxCyc);
      int k;
      k = 0;
      while (irq !== 1'b1 && k < maxCyc) begin
         @(posedge clk);
         k++;
      end
      `CHK("irq rises", 1'b1, irq)
   endtask

   // Period and frequency expected for a window of n slow periods
   task automatic chkResult(input int n);
      logic [31:0] per;
      logic [39:0] q;
      per = n * SLOW_P * 32 / 10;
      q = `SCMRC_FREQ_NUM / per;
      rdReg(`SCMRC_OFF_PERIOD, rv);
      `CHK("period", per, rv)
      rdReg(`SCMRC_OFF_FREQ, rv);
      `CHK("freq", {5'h0, q[26:0]}, rv)
      rdReg(`SCMRC_OFF_IRQ, rv);
      `CHK("pending", 32'h1, rv)
   endtask

   initial begin
      void'($urandom(32'h8d96e33a));
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      // Reset values, and an unmapped word
      rdReg(`SCMRC_OFF_CAUSE, rv);
      `CHK("cause rst", `SCMRC_CAUSE_RST, rv)
      rdReg(`SCMRC_OFF_WINDOW, rv);
      `CHK("window rst", {23'h0, `SCMRC_WINDOW_RST}, rv)
      rdReg(`SCMRC_OFF_PERIOD, rv);
      `CHK("period rst", 32'h0, rv)
      rdReg(`SCMRC_OFF_FREQ, rv);
      `CHK("freq rst", 32'h0, rv)
      rdReg(`SCMRC_OFF_IRQ, rv);
      `CHK("pending rst", 32'h0, rv)
      rdReg(`SCMRC_OFF_MASK, rv);
      `CHK("mask rst", 32'h1, rv)
      rdReg(8'h20, rv);
      `CHK("unmapped", 32'h0, rv)
      // Window field: all nine bits set and a random value, reserved bits zero
      wrReg(`SCMRC_OFF_WINDOW, 32'h1ff);
      rdReg(`SCMRC_OFF_WINDOW, rv);
      `CHK("window max", 32'h1ff, rv)
      expWin = {23'h0, 9'($urandom)};
      wrReg(`SCMRC_OFF_WINDOW, expWin);
      rdReg(`SCMRC_OFF_WINDOW, rv);
      `CHK("window rnd", expWin, rv)
      // Each cause input alone, newest replaces the register
      for (int i = 0; i < 9; i++) begin
         causeEvt <= scmrc_cause_t'(9'h1 << i);
         repeat (8) @(posedge clk);
         causeEvt <= '0;
         expCause = 32'h1 | (32'h1 << bitMap[i]);
         rdReg(`SCMRC_OFF_CAUSE, rv);
         `CHK("cause bit", expCause, rv)
      end
      wrReg(`SCMRC_OFF_CAUSE, 32'h1);
      rdReg(`SCMRC_OFF_CAUSE, rv);
      `CHK("cause ro", expCause, rv)
      // Software launch with a random short window
      win = 9'($urandom_range(8, 1));
      wrReg(`SCMRC_OFF_WINDOW, {23'h0, win});
      wrReg(`SCMRC_OFF_PERIOD, 32'h0);
      waitIrq(win * SLOW_P + 800);
      chkResult(win);
      // Writing zero keeps it pending, writing one clears it
      wrReg(`SCMRC_OFF_IRQ, 32'h0);
      rdReg(`SCMRC_OFF_IRQ, rv);
      `CHK("w0 keeps", 32'h1, rv)
      wrReg(`SCMRC_OFF_IRQ, 32'h1);
      rdReg(`SCMRC_OFF_IRQ, rv);
      `CHK("w1 clears", 32'h0, rv)
      `CHK("irq low", 1'b0, irq)
      // A nonzero write to the period register launches nothing
      wrReg(`SCMRC_OFF_PERIOD, 32'h1);
      repeat (win * SLOW_P + 800) @(posedge clk);
      rdReg(`SCMRC_OFF_IRQ, rv);
      `CHK("no launch", 32'h0, rv)
      // Masked auto measurement on power mode entry uses sixteen
      wrReg(`SCMRC_OFF_MASK, 32'h0);
      // A run in flight is dropped when mode entry restarts it
      wrReg(`SCMRC_OFF_PERIOD, 32'h0);
      secondActivePowerMode <= 1'b1;
      repeat (9 * SLOW_P + 400) @(posedge clk);
      rdReg(`SCMRC_OFF_IRQ, rv);
      `CHK("restart", 32'h0, rv)
      repeat (7 * SLOW_P + 400) @(posedge clk);
      secondActivePowerMode <= 1'b0;
      `CHK("irq masked", 1'b0, irq)
      chkResult(16);
      wrReg(`SCMRC_OFF_MASK, 32'h1);
      @(posedge clk);
      `CHK("irq unmasked", 1'b1, irq)
      // Results stand while nothing is launched
      repeat (50) @(posedge clk);
      chkResult(16);
      results();
   end
endmodule // testbench
